// ---- hdl/acb_pkg.sv ----
package acb_pkg;
	// Register addresses on the internal register port
	localparam logic [7:0] ADDR_FILT_RST = 8'h25;
	localparam logic [7:0] ADDR_BASE     = 8'h26;
	localparam logic [7:0] ADDR_STAT     = 8'h27;
	localparam logic [7:0] ADDR_X        = 8'h29;
	localparam logic [7:0] ADDR_Y        = 8'h2B;
	localparam logic [7:0] ADDR_Z        = 8'h2D;
	localparam logic [7:0] ADDR_CFG      = 8'h30;
	localparam logic [7:0] ADDR_SRC      = 8'h31;
	localparam logic [7:0] ADDR_THS      = 8'h32;
	localparam logic [7:0] ADDR_DUR      = 8'h33;

	// Reset values
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [6:0] RST_FIELD = 7'h00;
	localparam logic [5:0] RST_EVT   = 6'h00;

	// High-pass mode encodings
	localparam logic [1:0] MODE_NORM_A = 2'h0;
	localparam logic [1:0] MODE_REF    = 2'h1;
	localparam logic [1:0] MODE_NORM_B = 2'h2;

	// Field layout of configuration and source bytes
	localparam int         CFG_AND_BIT = 7;
	localparam logic [7:0] CFG_MASK    = 8'hBF;
	localparam logic [6:0] FIELD_MAX   = 7'h7F;
	localparam logic [6:0] CNT_STEP    = 7'h01;
	localparam logic [5:0] EVT_ALL     = 6'h3F;
	localparam int         EVT_W       = 6;
endpackage

// ---- hdl/acb_axis_stat.sv ----
`timescale 1ns/1ps
module acb_axis_stat #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Sample side
	input  wire logic         new_i,
	input  wire logic [W-1:0] data_i,
	// Host side
	input  wire logic         read_i,
	output logic      [W-1:0] sample_o,
	output logic              ready_o,
	output logic              overrun_o
);
	logic [W-1:0] nxt_sample;
	logic         nxt_ready;
	logic         nxt_overrun;

	// Fresh sample beats a host read in the same cycle
	always_comb begin
		nxt_sample  = new_i ? data_i : sample_o;
		nxt_ready   = new_i | (ready_o & ~read_i);
		// A read in the same cycle took the old value, so no overrun
		nxt_overrun = (new_i & ready_o & ~read_i) | (overrun_o & ~read_i);
	end

	// Flags start clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_o  <= '0;
			ready_o   <= 1'b0;
			overrun_o <= 1'b0;
		end else begin
			sample_o  <= nxt_sample;
			ready_o   <= nxt_ready;
			overrun_o <= nxt_overrun;
		end
	end

	property p_ready_set;
		@(posedge clk_i) disable iff (rst_i)
		new_i |=> ready_o && sample_o == $past(data_i);
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("axis ready not set by new sample");

	property p_overrun_set;
		@(posedge clk_i) disable iff (rst_i)
		new_i && ready_o && !read_i |=> overrun_o;
	endproperty
	a_overrun_set: assert property (p_overrun_set)
		else $error("axis overrun missed");
endmodule

// ---- hdl/acb_axis_cmp.sv ----
`timescale 1ns/1ps
module acb_axis_cmp #(
	parameter int W  = 8,
	parameter int TW = 7
) (
	// Sample and threshold
	input  wire logic [W-1:0]  sample_i,
	input  wire logic [TW-1:0] level_i,
	// Raw comparison results
	output logic               high_o,
	output logic               low_o
);
	logic signed [W-1:0] level_s;

	// Threshold is a positive figure against a signed sample
	always_comb begin
		level_s = $signed({{(W-TW){1'b0}}, level_i});
		high_o  = $signed(sample_i) > level_s;
		low_o   = $signed(sample_i) < level_s;
	end
endmodule

// ---- hdl/acb_accel_status.sv ----
// How it works
// - Mode 01 with filter on uses the baseline byte as filter reference.
// - Filter counts as on when any of three enable bits is one.
// - Combined ready flag is one when X, Y and Z all hold new data.
// - Each axis ready flag sets when a new sample lands in its register.
// - Combined overrun sets when a new sample hits an unread complete set.
// - Each axis overrun sets when a new sample replaces an unread one.
// - All eight status flags reset to zero.
// - X, Y and Z samples read as two's complement bytes at own addresses.
// - Enabled high event fires when an axis exceeds the threshold.
// - Enabled low event fires when an axis falls below the threshold.
// - Enabled events combine by OR when mode bit is zero, AND when one.
// - Active flag in source byte sets once an event is recognised.
// - Each axis high and low event has its own source flag.
// - Source byte is read-only; host writes to it are ignored.
// - Reading the source byte clears the active flag and the pin.
// - When latched, source contents hold until read, refresh only after.
// - Seven-bit threshold field, reset zero, compared with each axis.
// - Event recognised only after lasting the seven-bit hold count.
// - Mode 01 is reference filtering; 00 and 10 reset by dummy read.
// - Latch bit one latches requests until read; zero does not latch; here the active flag and pin still hold until read.
`timescale 1ns/1ps
module acb_accel_status #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Register port
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [7:0]   reg_wdata_i,
	output logic      [7:0]   reg_rdata_o,
	output logic              reg_rvalid_o,
	// Samples from the converter
	input  wire logic         x_new_i,
	input  wire logic [W-1:0] x_data_i,
	input  wire logic         y_new_i,
	input  wire logic [W-1:0] y_data_i,
	input  wire logic         z_new_i,
	input  wire logic [W-1:0] z_data_i,
	input  wire logic         rate_tick_i,
	// Control bits held elsewhere
	input  wire logic         filtered_data_select_i,
	input  wire logic         filter_on_path_one_i,
	input  wire logic         filter_on_path_two_i,
	input  wire logic [1:0]   highpass_mode_sel_i,
	input  wire logic         latch_first_request_i,
	// Filter and interrupt outputs
	output logic      [7:0]   baseline_value_o,
	output logic              filter_on_o,
	output logic              use_baseline_o,
	output logic              filter_clear_o,
	output logic              first_event_irq_o
);
	logic [W-1:0] x_sample, y_sample, z_sample;
	logic         x_ready, y_ready, z_ready;
	logic         x_overrun, y_overrun, z_overrun;
	logic         all_ready;
	logic         all_overrun_ff, nxt_all_overrun;
	logic [5:0]   ev_raw, ev_en;
	logic         cond, recognized;
	logic         src_rd, x_rd, y_rd, z_rd;
	logic [7:0]   cfg_ff, nxt_cfg;
	logic [6:0]   ths_ff, nxt_ths;
	logic [6:0]   dur_ff, nxt_dur;
	logic [6:0]   hold_cnt_ff, nxt_hold_cnt;
	logic [5:0]   src_flags_ff, nxt_src_flags;
	logic         act_ff, nxt_act;
	logic [7:0]   nxt_base;
	logic [7:0]   rd_mux, nxt_rdata;
	logic         nxt_filt_on, nxt_use_base, nxt_filt_clr;

	// Read strobes that carry side effects
	assign x_rd   = reg_rd_i && reg_addr_i == acb_pkg::ADDR_X;
	assign y_rd   = reg_rd_i && reg_addr_i == acb_pkg::ADDR_Y;
	assign z_rd   = reg_rd_i && reg_addr_i == acb_pkg::ADDR_Z;
	assign src_rd = reg_rd_i && reg_addr_i == acb_pkg::ADDR_SRC;

	// Per-axis sample, ready and overrun
	acb_axis_stat #(.W(W)) u_x_stat (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.new_i     (x_new_i),
		.data_i    (x_data_i),
		.read_i    (x_rd),
		.sample_o  (x_sample),
		.ready_o   (x_ready),
		.overrun_o (x_overrun)
	);
	acb_axis_stat #(.W(W)) u_y_stat (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.new_i     (y_new_i),
		.data_i    (y_data_i),
		.read_i    (y_rd),
		.sample_o  (y_sample),
		.ready_o   (y_ready),
		.overrun_o (y_overrun)
	);
	acb_axis_stat #(.W(W)) u_z_stat (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.new_i     (z_new_i),
		.data_i    (z_data_i),
		.read_i    (z_rd),
		.sample_o  (z_sample),
		.ready_o   (z_ready),
		.overrun_o (z_overrun)
	);

	// Threshold comparators, bit order matches the config enables
	acb_axis_cmp #(.W(W), .TW(7)) u_x_cmp (
		.sample_i (x_sample),
		.level_i  (ths_ff),
		.high_o   (ev_raw[1]),
		.low_o    (ev_raw[0])
	);
	acb_axis_cmp #(.W(W), .TW(7)) u_y_cmp (
		.sample_i (y_sample),
		.level_i  (ths_ff),
		.high_o   (ev_raw[3]),
		.low_o    (ev_raw[2])
	);
	acb_axis_cmp #(.W(W), .TW(7)) u_z_cmp (
		.sample_i (z_sample),
		.level_i  (ths_ff),
		.high_o   (ev_raw[5]),
		.low_o    (ev_raw[4])
	);

	// Combined status; overrun stays until every axis has been read
	always_comb begin
		all_ready       = x_ready & y_ready & z_ready;
		nxt_all_overrun = ((x_new_i | y_new_i | z_new_i) & all_ready)
			| (all_overrun_ff & (x_ready | y_ready | z_ready));
	end

	// Event combination and hold counter
	always_comb begin
		ev_en = ev_raw & cfg_ff[5:0];
		if (cfg_ff[acb_pkg::CFG_AND_BIT]) begin
			// AND mode needs at least one enable or it would always fire
			cond = (cfg_ff[5:0] != acb_pkg::RST_EVT)
				&& ((ev_raw | ~cfg_ff[5:0]) == acb_pkg::EVT_ALL);
		end else begin
			cond = |ev_en;
		end
		if (!cond) begin
			nxt_hold_cnt = acb_pkg::RST_FIELD;
		end else if (rate_tick_i && hold_cnt_ff != acb_pkg::FIELD_MAX) begin
			nxt_hold_cnt = hold_cnt_ff + acb_pkg::CNT_STEP;
		end else begin
			nxt_hold_cnt = hold_cnt_ff;
		end
		recognized = cond && (hold_cnt_ff >= dur_ff);
	end

	// Source byte update; a new event wins over the clearing read
	always_comb begin
		nxt_src_flags = src_flags_ff;
		nxt_act       = act_ff;
		if (src_rd) begin
			nxt_act = 1'b0;
		end
		if (!latch_first_request_i) begin
			// Unlatched: flags follow the live condition
			nxt_src_flags = recognized ? ev_en : acb_pkg::RST_EVT;
			if (recognized) begin
				nxt_act = 1'b1;
			end
		end else if (recognized && (!act_ff || src_rd)) begin
			nxt_src_flags = ev_en;
			nxt_act       = 1'b1;
		end else if (src_rd) begin
			nxt_src_flags = acb_pkg::RST_EVT;
		end
	end

	// Host writes; source, status and samples have no write path
	always_comb begin
		nxt_base = baseline_value_o;
		nxt_cfg  = cfg_ff;
		nxt_ths  = ths_ff;
		nxt_dur  = dur_ff;
		if (reg_wr_i) begin
			case (reg_addr_i)
				acb_pkg::ADDR_BASE: begin
					nxt_base = reg_wdata_i;
				end
				acb_pkg::ADDR_CFG: begin
					nxt_cfg = reg_wdata_i & acb_pkg::CFG_MASK;
				end
				acb_pkg::ADDR_THS: begin
					nxt_ths = reg_wdata_i[6:0];
				end
				acb_pkg::ADDR_DUR: begin
					nxt_dur = reg_wdata_i[6:0];
				end
				default: begin
					nxt_base = baseline_value_o;
				end
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr_i)
			acb_pkg::ADDR_BASE: rd_mux = baseline_value_o;
			acb_pkg::ADDR_STAT: rd_mux = {all_overrun_ff, z_overrun, y_overrun,
				x_overrun, all_ready, z_ready, y_ready, x_ready};
			acb_pkg::ADDR_X:    rd_mux = x_sample;
			acb_pkg::ADDR_Y:    rd_mux = y_sample;
			acb_pkg::ADDR_Z:    rd_mux = z_sample;
			acb_pkg::ADDR_CFG:  rd_mux = cfg_ff;
			acb_pkg::ADDR_SRC:  rd_mux = {1'b0, act_ff, src_flags_ff};
			acb_pkg::ADDR_THS:  rd_mux = {1'b0, ths_ff};
			acb_pkg::ADDR_DUR:  rd_mux = {1'b0, dur_ff};
			default:            rd_mux = acb_pkg::RST_BYTE;
		endcase
		nxt_rdata = reg_rd_i ? rd_mux : reg_rdata_o;
	end

	// Filter steering; mode 11 is undefined and does nothing
	always_comb begin
		nxt_filt_on  = filtered_data_select_i | filter_on_path_one_i
			| filter_on_path_two_i;
		nxt_use_base = nxt_filt_on
			&& highpass_mode_sel_i == acb_pkg::MODE_REF;
		nxt_filt_clr = reg_rd_i && reg_addr_i == acb_pkg::ADDR_FILT_RST
			&& nxt_filt_on
			&& (highpass_mode_sel_i == acb_pkg::MODE_NORM_A
			|| highpass_mode_sel_i == acb_pkg::MODE_NORM_B);
	end

	// All state registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			all_overrun_ff    <= 1'b0;
			cfg_ff            <= acb_pkg::RST_BYTE;
			ths_ff            <= acb_pkg::RST_FIELD;
			dur_ff            <= acb_pkg::RST_FIELD;
			hold_cnt_ff       <= acb_pkg::RST_FIELD;
			src_flags_ff      <= acb_pkg::RST_EVT;
			act_ff            <= 1'b0;
			first_event_irq_o <= 1'b0;
			baseline_value_o  <= acb_pkg::RST_BYTE;
			reg_rdata_o       <= acb_pkg::RST_BYTE;
			reg_rvalid_o      <= 1'b0;
			filter_on_o       <= 1'b0;
			use_baseline_o    <= 1'b0;
			filter_clear_o    <= 1'b0;
		end else begin
			all_overrun_ff    <= nxt_all_overrun;
			cfg_ff            <= nxt_cfg;
			ths_ff            <= nxt_ths;
			dur_ff            <= nxt_dur;
			hold_cnt_ff       <= nxt_hold_cnt;
			src_flags_ff      <= nxt_src_flags;
			act_ff            <= nxt_act;
			first_event_irq_o <= nxt_act;
			baseline_value_o  <= nxt_base;
			reg_rdata_o       <= nxt_rdata;
			reg_rvalid_o      <= reg_rd_i;
			filter_on_o       <= nxt_filt_on;
			use_baseline_o    <= nxt_use_base;
			filter_clear_o    <= nxt_filt_clr;
		end
	end

	// Checks on the running block
	sequence s_read_src_quiet;
		src_rd && !recognized;
	endsequence

	sequence s_latched_pending;
		latch_first_request_i && act_ff && !src_rd;
	endsequence

	property p_filter_on;
		@(posedge clk_i) disable iff (rst_i)
		(filtered_data_select_i || filter_on_path_one_i
			|| filter_on_path_two_i) |=> filter_on_o;
	endproperty
	a_filter_on: assert property (p_filter_on)
		else $error("filter not reported on");

	property p_use_base;
		@(posedge clk_i) disable iff (rst_i)
		use_baseline_o |-> filter_on_o
			&& $past(highpass_mode_sel_i) == acb_pkg::MODE_REF;
	endproperty
	a_use_base: assert property (p_use_base)
		else $error("baseline used outside reference mode");

	property p_filt_clr;
		@(posedge clk_i) disable iff (rst_i)
		filter_clear_o |-> $past(reg_addr_i) == acb_pkg::ADDR_FILT_RST
			&& $past(highpass_mode_sel_i) != acb_pkg::MODE_REF;
	endproperty
	a_filt_clr: assert property (p_filt_clr)
		else $error("filter clear without dummy read");

	property p_all_ready;
		@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == acb_pkg::ADDR_STAT
			|=> reg_rvalid_o && reg_rdata_o[3] == $past(all_ready);
	endproperty
	a_all_ready: assert property (p_all_ready)
		else $error("combined ready mismatch");

	property p_all_overrun;
		@(posedge clk_i) disable iff (rst_i)
		(x_new_i || y_new_i || z_new_i) && all_ready |=> all_overrun_ff;
	endproperty
	a_all_overrun: assert property (p_all_overrun)
		else $error("combined overrun missed");

	property p_irq_set;
		@(posedge clk_i) disable iff (rst_i)
		recognized |=> first_event_irq_o && act_ff;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("event recognised but pin low");

	property p_src_clear;
		@(posedge clk_i) disable iff (rst_i)
		s_read_src_quiet |=> !first_event_irq_o;
	endproperty
	a_src_clear: assert property (p_src_clear)
		else $error("source read did not clear pin");

	property p_src_ro;
		@(posedge clk_i) disable iff (rst_i)
		reg_wr_i && !reg_rd_i && reg_addr_i == acb_pkg::ADDR_SRC
			&& !recognized |=> act_ff == $past(act_ff);
	endproperty
	a_src_ro: assert property (p_src_ro)
		else $error("write changed source byte");

	property p_latch_hold;
		@(posedge clk_i) disable iff (rst_i)
		s_latched_pending |=> $stable(src_flags_ff) && act_ff;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched source changed before read");

	property p_hold_count;
		@(posedge clk_i) disable iff (rst_i)
		cond && rate_tick_i && hold_cnt_ff != acb_pkg::FIELD_MAX
			|=> hold_cnt_ff == $past(hold_cnt_ff) + acb_pkg::CNT_STEP;
	endproperty
	a_hold_count: assert property (p_hold_count)
		else $error("hold counter did not step");

	property p_hold_gate;
		@(posedge clk_i) disable iff (rst_i)
		!latch_first_request_i && cond && hold_cnt_ff < dur_ff
			&& !act_ff && !$past(recognized) |=> !first_event_irq_o;
	endproperty
	a_hold_gate: assert property (p_hold_gate)
		else $error("event fired before hold time");

	property p_or_mode;
		@(posedge clk_i) disable iff (rst_i)
		!cfg_ff[acb_pkg::CFG_AND_BIT] && |ev_en
			&& dur_ff == acb_pkg::RST_FIELD |=> first_event_irq_o;
	endproperty
	a_or_mode: assert property (p_or_mode)
		else $error("OR combination missed event");
endmodule

// ---- tb/acb_host.sv ----
`timescale 1ns/1ps
module acb_host (
	// Clock
	input  wire logic       clk_i,
	// Register port toward the device
	output logic      [7:0] reg_addr_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_wdata_o,
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i
);
	// Idle bus at time zero
	initial begin
		reg_addr_o  = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// One-cycle strobe; idle lines flip so stale values never match
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_o  = a;
		reg_wdata_o = d;
		reg_wr_o    = 1'b1;
		@(negedge clk_i);
		reg_wr_o    = 1'b0;
		reg_addr_o  = ~a;
		reg_wdata_o = ~d;
	endtask

	// Read pulse; valid stands only one cycle, so take it before release
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk_i);
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(negedge clk_i);
		v          = reg_rvalid_i;
		d          = reg_rdata_i;
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
		@(negedge clk_i);
	endtask
endmodule

// ---- tb/tb_acb_accel_status.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
	end \
end
module tb_acb_accel_status;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] wd;
		logic [7:0] ex;
	} acb_row_t;

	logic       clk_i, rst_i, wr, rd, rvalid, tick, fsel, p1, p2, lat;
	logic       xn, yn, zn, fon, ubase, fclr, irq, on, v;
	logic [7:0] addr, wdata, rdata, xd, yd, zd, base, d, nclr, nexp;
	logic [1:0] hp_sel;
	int         errors, cmp_count;
	acb_row_t   rows [8] = '{
		'{acb_pkg::ADDR_BASE, 8'hA5, 8'hA5},
		'{acb_pkg::ADDR_CFG,  8'hFF, 8'hBF},
		'{acb_pkg::ADDR_THS,  8'hFF, 8'h7F},
		'{acb_pkg::ADDR_DUR,  8'hFF, 8'h7F},
		'{acb_pkg::ADDR_SRC,  8'hFF, 8'h00},
		'{acb_pkg::ADDR_STAT, 8'hFF, 8'h00},
		'{acb_pkg::ADDR_X,    8'hFF, 8'h00},
		'{8'h40,              8'hFF, 8'h00}
	};

	acb_accel_status #(.W(8)) acb_accel_status_i (
		.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .x_new_i(xn), .x_data_i(xd), .y_new_i(yn),
		.y_data_i(yd), .z_new_i(zn), .z_data_i(zd), .rate_tick_i(tick),
		.filtered_data_select_i(fsel), .filter_on_path_one_i(p1),
		.filter_on_path_two_i(p2), .highpass_mode_sel_i(hp_sel),
		.latch_first_request_i(lat), .baseline_value_o(base),
		.filter_on_o(fon), .use_baseline_o(ubase),
		.filter_clear_o(fclr), .first_event_irq_o(irq)
	);

	acb_host acb_host_i (
		.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid)
	);

	// Free-running 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Counts clear pulses so none slips past between checks
	always @(posedge clk_i) begin
		if (fclr === 1'b1)
			nclr <= nclr + 8'h01;
	end

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		acb_host_i.rd(a, d, v);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask

	// Strobes only the axes in the mask; data flips once taken
	task automatic smp(input logic [2:0] m, input logic [7:0] x,
		input logic [7:0] y, input logic [7:0] z);
		@(negedge clk_i);
		{zn, yn, xn} = m;
		xd = x;
		yd = y;
		zd = z;
		@(negedge clk_i);
		{zn, yn, xn} = 3'h0;
		xd = ~x;
		yd = ~y;
		zd = ~z;
	endtask

	task automatic tk();
		@(negedge clk_i);
		tick = 1'b1;
		@(negedge clk_i);
		tick = 1'b0;
		repeat (2) @(negedge clk_i);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// Main sequence
	initial begin
		{rst_i, xn, yn, zn, tick, fsel, p1, p2, lat} = 9'h100;
		{xd, yd, zd, nclr} = 32'h0;
		hp_sel = 2'h0;
		errors = 0;
		cmp_count = 0;
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		foreach (rows[i]) begin
			rchk(rows[i].a, 8'h00);
			acb_host_i.wr(rows[i].a, rows[i].wd);
			rchk(rows[i].a, rows[i].ex);
		end
		acb_host_i.wr(acb_pkg::ADDR_CFG, 8'h00);
		$display("test registers done");

		for (int e = 0; e < 4; e++) begin
			for (int m = 0; m < 4; m++) begin
				{fsel, p1, p2} = (e == 0) ? 3'h0 : 3'h4 >> (e - 1);
				hp_sel = m[1:0];
				repeat (2) @(negedge clk_i);
				on = (e != 0);
				`CHK(fon, on)
				`CHK(ubase, on && m == 1)
				`CHK(base, 8'hA5)
				nexp = nclr + {7'h00, on && !m[0]};
				rchk(acb_pkg::ADDR_FILT_RST, 8'h00);
				`CHK(nclr, nexp)
			end
		end
		{fsel, p1, p2} = 3'h0;
		$display("test filter done");

		smp(3'h1, 8'h11, 8'h00, 8'h00);
		rchk(acb_pkg::ADDR_STAT, 8'h01);
		rchk(acb_pkg::ADDR_X, 8'h11);
		rchk(acb_pkg::ADDR_STAT, 8'h00);
		smp(3'h7, 8'h80, 8'h7F, 8'hFE);
		rchk(acb_pkg::ADDR_STAT, 8'h0F);
		smp(3'h7, 8'h81, 8'h01, 8'hFF);
		rchk(acb_pkg::ADDR_STAT, 8'hFF);
		rchk(acb_pkg::ADDR_X, 8'h81);
		rchk(acb_pkg::ADDR_STAT, 8'hE6);
		rchk(acb_pkg::ADDR_Y, 8'h01);
		rchk(acb_pkg::ADDR_Z, 8'hFF);
		rchk(acb_pkg::ADDR_STAT, 8'h00);
		$display("test status done");

		// Unlatched OR of x high and z high
		acb_host_i.wr(acb_pkg::ADDR_THS, 8'h20);
		acb_host_i.wr(acb_pkg::ADDR_DUR, 8'h00);
		acb_host_i.wr(acb_pkg::ADDR_CFG, 8'h22);
		smp(3'h7, 8'h21, 8'h00, 8'h00);
		repeat (2) @(negedge clk_i);
		`CHK(irq, 1'b1)
		rchk(acb_pkg::ADDR_SRC, 8'h42);
		smp(3'h1, 8'h20, 8'h00, 8'h00);
		acb_host_i.rd(acb_pkg::ADDR_SRC, d, v);
		`CHK(d, 8'h40)
		rchk(acb_pkg::ADDR_SRC, 8'h00);
		`CHK(irq, 1'b0)
		$display("test unlatched done");

		// Latched AND of x high and signed y low, hold two periods
		lat = 1'b1;
		acb_host_i.wr(acb_pkg::ADDR_DUR, 8'h02);
		acb_host_i.wr(acb_pkg::ADDR_CFG, 8'h86);
		smp(3'h7, 8'h30, 8'h25, 8'h00);
		repeat (3) tk();
		`CHK(irq, 1'b0)
		smp(3'h2, 8'h30, 8'hF0, 8'h00);
		tk();
		`CHK(irq, 1'b0)
		smp(3'h2, 8'h30, 8'h25, 8'h00);
		smp(3'h2, 8'h30, 8'hF0, 8'h00);
		tk();
		`CHK(irq, 1'b0)
		tk();
		`CHK(irq, 1'b1)
		smp(3'h1, 8'h00, 8'hF0, 8'h00);
		repeat (2) @(negedge clk_i);
		`CHK(irq, 1'b1)
		acb_host_i.wr(acb_pkg::ADDR_SRC, 8'h00);
		rchk(acb_pkg::ADDR_SRC, 8'h46);
		`CHK(irq, 1'b0)
		rchk(acb_pkg::ADDR_SRC, 8'h00);
		$display("test latched done");

		// Reset in mid-run with flags and the pin standing
		acb_host_i.wr(acb_pkg::ADDR_DUR, 8'h00);
		smp(3'h7, 8'h30, 8'hF0, 8'h03);
		@(negedge clk_i);
		`CHK(irq, 1'b1)
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		`CHK(irq, 1'b0)
		rchk(acb_pkg::ADDR_STAT, 8'h00);
		rchk(acb_pkg::ADDR_CFG, 8'h00);
		$display("test reset done");
		tally_and_finish();
	end
endmodule
